// ===== dv/svsf_net_model.sv
`timescale 1ns/1ps
// host table image plus slave network; bench steers it through its tasks
module svsf_net_model (
    output logic [15:0] out_reg_table,
    output logic [15:0] in_reg_table,
    output logic [15:0] monitor_time,
    output logic [15:0] out_active,
    output logic [15:0] in_active,
    output logic [15:0] out_comm_err,
    output logic [15:0] in_comm_err
);
    // tables change at a restart, or once without one to show the block samples them once
    task automatic load(input logic [15:0] o, input logic [15:0] i, input logic [15:0] t);
        out_reg_table = o;
        in_reg_table  = i;
        monitor_time  = t;
    endtask
    // a joining slave drops its error flag
    task automatic join_net(input logic [15:0] o, input logic [15:0] i);
        out_active   = out_active | o;
        in_active    = in_active | i;
        out_comm_err = out_comm_err & ~o;
        in_comm_err  = in_comm_err & ~i;
    endtask
    // a withdrawn slave raises its error flag
    task automatic fail(input logic [15:0] o, input logic [15:0] i);
        out_comm_err = out_comm_err | o;
        in_comm_err  = in_comm_err | i;
    endtask
    // whole network silent, as after a restart
    task automatic clear_all();
        out_active   = 16'h0000;
        in_active    = 16'h0000;
        out_comm_err = 16'h0000;
        in_comm_err  = 16'h0000;
    endtask
    initial begin
        load(16'h0000, 16'h0000, 16'h0000);
        clear_all();
    end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import svsf_pkg::*;
    localparam int LIMIT = 4000;
    logic        clk;
    logic        srst;
    logic        unit_restart;
    logic        reg_enable;
    logic        stop_mode_enable;
    logic        rd_en;
    logic [3:0]  rd_addr;
    logic [15:0] ort, irt, mt, oa, ia, oe, ie;
    logic [15:0] rd_data;
    logic [15:0] status_word;
    logic [15:0] node_word;
    logic        exchange_halt;
    int          num_errors;
    int          check_count;
    int          cycles;

    svsf_net_model u_net (.out_reg_table(ort), .in_reg_table(irt), .monitor_time(mt),
        .out_active(oa), .in_active(ia), .out_comm_err(oe), .in_comm_err(ie));

    // short monitoring unit of 4 cycles keeps the windows 20 cycles long at most
    svsf_status_flags #(.MON_UNIT_CYC_P(4)) u_dut (.clk(clk), .srst(srst),
        .unit_restart(unit_restart), .reg_enable(reg_enable),
        .stop_mode_enable(stop_mode_enable), .out_reg_table(ort), .in_reg_table(irt),
        .monitor_time(mt), .out_active(oa), .in_active(ia), .out_comm_err(oe),
        .in_comm_err(ie), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .status_word(status_word), .node_word(node_word), .exchange_halt(exchange_halt));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one read: strobe held across the taking edge, data looked at half a cycle later
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        check(rd_data, exp);
        @(negedge clk);
    endtask

    // restart with new tables; LOAD then WATCH follow
    task automatic restart(input logic [15:0] o, input logic [15:0] i, input logic [15:0] t);
        u_net.load(o, i, t);
        u_net.clear_all();
        unit_restart = 1'b1;
        @(negedge clk);
        unit_restart = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic test_reset();
        rd_check(SVSF_STATUS_OFS, 16'h0000);
        rd_check(SVSF_NODE_OFS, 16'h0000);
        rd_check(4'h3, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_done();
        reg_enable = 1'b1;
        restart(16'h0006, 16'h0000, 16'h0005);
        u_net.join_net(16'h0006, 16'h0001);
        repeat (5) @(negedge clk);
        rd_check(SVSF_STATUS_OFS, 16'h8201);
        u_net.clear_all();
        repeat (40) @(negedge clk);
        check(status_word, 16'h8201);
        check(status_word, 16'h8201);
        $display("test done done");
    endtask

    task automatic test_missing();
        restart(16'h0003, 16'h0000, 16'h0002);
        u_net.join_net(16'h0001, 16'h0000);
        repeat (30) @(negedge clk);
        check(status_word, 16'h8100);
        u_net.join_net(16'h0002, 16'h0000);
        repeat (2) @(negedge clk);
        check(status_word, 16'h0000);
        restart(16'h0000, 16'h0000, 16'h0002);
        repeat (30) @(negedge clk);
        check(status_word, 16'h0000);
        // a table edit without restart must not be taken: node 0 stays a stranger
        u_net.load(16'h0001, 16'h0000, 16'h0000);
        u_net.join_net(16'h0001, 16'h0000);
        repeat (2) @(negedge clk);
        check(status_word, 16'h8200);
        $display("test missing done");
    endtask

    task automatic stop_case(input logic [15:0] o, input logic [15:0] i, input logic [15:0] n);
        stop_mode_enable = 1'b1;
        restart(16'h0000, 16'h0000, 16'h0001);
        u_net.fail(o, i);
        #1;
        check({15'h0000, exchange_halt}, 16'h0001);
        @(negedge clk);
        check(status_word, 16'h8400);
        rd_check(SVSF_NODE_OFS, n);
        check(node_word, n);
        u_net.fail(16'h0001, 16'h8000);
        repeat (3) @(negedge clk);
        check(node_word, n);
        u_net.join_net(16'hFFFF, 16'hFFFF);
        repeat (3) @(negedge clk);
        check(status_word, 16'h8400);
        check(status_word, 16'h8400);
        stop_mode_enable = 1'b0;
        restart(16'h0000, 16'h0000, 16'h0001);
        check(status_word, 16'h0000);
        check(node_word, 16'h0000);
        check({15'h0000, exchange_halt}, 16'h0000);
    endtask

    task automatic test_stop();
        reg_enable = 1'b0;
        stop_case(16'h0000, 16'h0400, 16'h800A);
        stop_case(16'h0008, 16'h0000, 16'h0003);
        $display("test stop done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        num_errors       = 0;
        check_count      = 0;
        cycles           = 0;
        srst             = 1'b1;
        unit_restart     = 1'b0;
        reg_enable       = 1'b0;
        stop_mode_enable = 1'b0;
        rd_en            = 1'b0;
        rd_addr          = 4'h0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        test_reset();
        test_done();
        test_missing();
        test_stop();
        final_report();
    end
endmodule

// ===== hdl/svsf_pkg.sv
// How it works
// R1 - set done when all registered slaves join in time
// R2 - never set done with an empty table
// R3 - done flag sticks until reset or restart
// R4 - set missing flag when monitor time expires short
// R5 - missing flag clears once the late slaves join
// R6 - set unregistered flag when unknown slave joins
// R7 - unregistered flag sticks even after slave leaves
// R8 - set stopped flag on error in stop mode
// R9 - stopped flag sticks until reset or restart
// R10 - summary bit 15 is OR of bits 8 to 10
// R11 - latch failing node number into word 5 low byte
// R12 - stored node number held until reset or restart
// R13 - latch failing slave type into word 5 bit 15
// R14 - host keeps words 0 to 9 for this use
// R15 - tables and monitor time taken only at start
// R16 - halt exchange at once on error in stop mode
// R17 - reset or restart clears all latched state
package svsf_pkg;

    // word offsets within the status area
    localparam logic [3:0]  SVSF_STATUS_OFS  = 4'h4;
    localparam logic [3:0]  SVSF_NODE_OFS    = 4'h5;

    // field positions of the status flag word
    localparam int          SVSF_BIT_DONE    = 0;
    localparam int          SVSF_BIT_MISSING = 8;
    localparam int          SVSF_BIT_UNREG   = 9;
    localparam int          SVSF_BIT_STOPPED = 10;
    localparam int          SVSF_BIT_ERROR   = 15;

    // field positions of the stopped node word
    localparam int          SVSF_NODE_LSB    = 0;
    localparam int          SVSF_NODE_W      = 8;
    localparam int          SVSF_BIT_TYPE    = 15;

    // reset values
    localparam logic [15:0] SVSF_WORD_RST    = 16'h0000;
    localparam logic [7:0]  SVSF_NODE_RST    = 8'h00;
    localparam logic [31:0] SVSF_MAP_RST     = 32'h0000_0000;

    // slave type codes stored with a stop
    localparam logic        SVSF_TYPE_OUT    = 1'b0;
    localparam logic        SVSF_TYPE_IN     = 1'b1;

    // timing: one unit of the monitoring time value
    localparam int          SVSF_CLK_HZ      = 40_000_000;
    localparam int          SVSF_MON_UNIT_MS = 100;
    localparam int          SVSF_MON_UNIT_CYC = SVSF_MON_UNIT_MS * (SVSF_CLK_HZ / 1000);

    // supervision phase after start
    typedef enum logic [1:0] {
        SVSF_LOAD,
        SVSF_WATCH,
        SVSF_DONE
    } svsf_phase_type;

endpackage

// ===== hdl/svsf_status_flags.sv
`timescale 1ns/1ps
module svsf_status_flags #(
    parameter int MON_UNIT_CYC_P = svsf_pkg::SVSF_MON_UNIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        unit_restart,
    input  wire logic        reg_enable,
    input  wire logic        stop_mode_enable,
    input  wire logic [15:0] out_reg_table,
    input  wire logic [15:0] in_reg_table,
    input  wire logic [15:0] monitor_time,
    input  wire logic [15:0] out_active,
    input  wire logic [15:0] in_active,
    input  wire logic [15:0] out_comm_err,
    input  wire logic [15:0] in_comm_err,
    input  wire logic        rd_en,
    input  wire logic [3:0]  rd_addr,
    output logic [15:0]      rd_data,
    output logic [15:0]      status_word,
    output logic [15:0]      node_word,
    output logic             exchange_halt
);
    import svsf_pkg::*;

    // lowest set bit of a 16-bit error map, as a node number
    function automatic logic [7:0] svsf_first_node(input logic [15:0] map);
        logic [7:0] idx;
        idx = SVSF_NODE_RST;
        for (int i = 15; i >= 0; i--) begin
            if (map[i]) begin
                idx = 8'(i);
            end
        end
        return idx;
    endfunction

    svsf_phase_type phase_q;
    svsf_phase_type phase_d;
    logic [31:0]    table_q;
    logic [31:0]    table_d;
    logic [15:0]    mon_time_q;
    logic [15:0]    mon_time_d;
    logic [31:0]    pre_q;
    logic [31:0]    pre_d;
    logic [15:0]    units_q;
    logic [15:0]    units_d;
    logic           done_q;
    logic           done_d;
    logic [31:0]    miss_map_q;
    logic [31:0]    miss_map_d;
    logic           unreg_q;
    logic           unreg_d;
    logic           stopped_q;
    logic           stopped_d;
    logic [7:0]     node_q;
    logic [7:0]     node_d;
    logic           type_q;
    logic           type_d;
    logic [15:0]    rd_data_q;
    logic [15:0]    rd_data_d;

    logic [31:0]    active_all;
    logic [31:0]    absent_reg;
    logic           all_joined;
    logic           stranger;
    logic           any_err;
    logic           stop_now;
    logic           restart;

    // network state viewed as one 32-bit map, outputs low, inputs high
    assign active_all = {in_active, out_active};
    assign absent_reg = table_q & ~active_all;
    assign all_joined = (table_q != SVSF_MAP_RST) && (absent_reg == SVSF_MAP_RST);
    assign stranger   = |(active_all & ~table_q);
    assign any_err    = |{out_comm_err, in_comm_err};
    assign stop_now   = stop_mode_enable && any_err;
    assign restart    = srst || unit_restart;

    // halt is combinational so exchange stops in the very cycle of the error
    assign exchange_halt = stopped_q || stop_now; // R16

    // status words assembled from the latched flags
    always_comb begin
        status_word                   = SVSF_WORD_RST;
        status_word[SVSF_BIT_DONE]    = done_q;
        status_word[SVSF_BIT_MISSING] = |miss_map_q; // R4
        status_word[SVSF_BIT_UNREG]   = unreg_q;
        status_word[SVSF_BIT_STOPPED] = stopped_q;
        status_word[SVSF_BIT_ERROR]   = |miss_map_q || unreg_q || stopped_q; // R10
        node_word                     = SVSF_WORD_RST;
        node_word[SVSF_NODE_LSB +: SVSF_NODE_W] = node_q;
        node_word[SVSF_BIT_TYPE]      = type_q;
    end

    // next state of supervision, flags and the read port
    always_comb begin
        phase_d    = phase_q;
        table_d    = table_q;
        mon_time_d = mon_time_q;
        pre_d      = pre_q;
        units_d    = units_q;
        done_d     = done_q;
        miss_map_d = miss_map_q & ~active_all; // R5
        unreg_d    = unreg_q;
        stopped_d  = stopped_q;
        node_d     = node_q;
        type_d     = type_q;
        rd_data_d  = SVSF_WORD_RST;

        case (phase_q)
            SVSF_LOAD: begin
                // tables are sampled once after start; later edits need a restart
                table_d    = {in_reg_table, out_reg_table}; // R15
                mon_time_d = monitor_time; // R15
                pre_d      = '0;
                units_d    = '0;
                phase_d    = SVSF_WATCH;
            end
            SVSF_WATCH: begin
                if (reg_enable && all_joined) begin
                    done_d  = 1'b1; // R1 R2
                    phase_d = SVSF_DONE;
                end else if (units_q >= mon_time_q) begin
                    if (reg_enable) begin
                        miss_map_d = absent_reg; // R4
                    end
                    phase_d = SVSF_DONE;
                end else if (pre_q >= 32'(MON_UNIT_CYC_P - 1)) begin
                    pre_d   = '0;
                    units_d = units_q + 16'h0001;
                end else begin
                    pre_d = pre_q + 32'h0000_0001;
                end
            end
            default: begin
                // done and missing only evolve by the latched state here
                phase_d = SVSF_DONE; // R3
            end
        endcase

        // unknown slaves are checked outside LOAD while reg_enable is high, and the flag sticks
        if (phase_q != SVSF_LOAD && reg_enable && stranger) begin
            unreg_d = 1'b1; // R6 R7
        end

        // first error in stop mode freezes node and type
        if (stop_now && !stopped_q) begin // R12
            stopped_d = 1'b1; // R8 R9
            if (|out_comm_err) begin
                node_d = svsf_first_node(out_comm_err); // R11
                type_d = SVSF_TYPE_OUT; // R13
            end else begin
                node_d = svsf_first_node(in_comm_err); // R11
                type_d = SVSF_TYPE_IN; // R13
            end
        end

        // read port: unmapped words read as zero
        if (rd_en) begin
            if (rd_addr == SVSF_STATUS_OFS) begin
                rd_data_d = status_word;
            end else if (rd_addr == SVSF_NODE_OFS) begin
                rd_data_d = node_word;
            end else begin
                rd_data_d = SVSF_WORD_RST;
            end
        end

        // restart wipes every latch and re-reads the tables
        if (restart) begin
            phase_d    = SVSF_LOAD; // R17
            done_d     = 1'b0;
            miss_map_d = SVSF_MAP_RST;
            unreg_d    = 1'b0;
            stopped_d  = 1'b0;
            node_d     = SVSF_NODE_RST;
            type_d     = SVSF_TYPE_OUT;
        end
    end

    // registers only; synchronous reset
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q    <= SVSF_LOAD; // R17
            table_q    <= SVSF_MAP_RST;
            mon_time_q <= SVSF_WORD_RST;
            pre_q      <= '0;
            units_q    <= '0;
            done_q     <= 1'b0;
            miss_map_q <= SVSF_MAP_RST;
            unreg_q    <= 1'b0;
            stopped_q  <= 1'b0;
            node_q     <= SVSF_NODE_RST;
            type_q     <= SVSF_TYPE_OUT;
            rd_data_q  <= SVSF_WORD_RST;
        end else begin
            phase_q    <= phase_d;
            table_q    <= table_d;
            mon_time_q <= mon_time_d;
            pre_q      <= pre_d;
            units_q    <= units_d;
            done_q     <= done_d;
            miss_map_q <= miss_map_d;
            unreg_q    <= unreg_d;
            stopped_q  <= stopped_d;
            node_q     <= node_d;
            type_q     <= type_d;
            rd_data_q  <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    done_never_empty_a: assert property ( // R2
        done_q |-> (table_q != SVSF_MAP_RST))
        else $error("done flag set with empty table");

    done_on_join_a: assert property ( // R1
        (phase_q == SVSF_WATCH) && reg_enable && all_joined && !unit_restart |=> done_q)
        else $error("done flag missed full join");

    done_sticky_a: assert property ( // R3
        done_q && !unit_restart |=> done_q)
        else $error("done flag dropped without restart");

    missing_set_a: assert property ( // R4
        (phase_q == SVSF_WATCH) && reg_enable && !all_joined && (units_q >= mon_time_q)
        && (absent_reg != SVSF_MAP_RST) && !unit_restart |=> status_word[SVSF_BIT_MISSING])
        else $error("missing flag not set at expiry");

    missing_clear_a: assert property ( // R5
        status_word[SVSF_BIT_MISSING] && ((miss_map_q & ~active_all) == SVSF_MAP_RST)
        |=> !status_word[SVSF_BIT_MISSING])
        else $error("missing flag kept after slaves joined");

    unreg_set_a: assert property ( // R6
        (phase_q != SVSF_LOAD) && reg_enable && stranger && !unit_restart |=> unreg_q)
        else $error("unregistered flag not set");

    unreg_sticky_a: assert property ( // R7
        unreg_q && !unit_restart |=> unreg_q)
        else $error("unregistered flag dropped");

    stop_set_a: assert property ( // R8
        stop_now && !unit_restart |=> stopped_q ##0 status_word[SVSF_BIT_STOPPED])
        else $error("stopped flag not set on error");

    stop_hold_a: assert property ( // R9 R12 R13
        stopped_q && !unit_restart |=> stopped_q && $stable(node_q) && $stable(type_q))
        else $error("stop record changed without restart");

    stop_node_a: assert property ( // R11 R13
        stop_now && !stopped_q && !unit_restart && (out_comm_err == 16'h0008)
        |=> (node_word[7:0] == 8'h03) && !node_word[SVSF_BIT_TYPE])
        else $error("stopped node or type wrong");

    summary_bit_a: assert property ( // R10
        status_word[SVSF_BIT_ERROR] == (|status_word[SVSF_BIT_STOPPED:SVSF_BIT_MISSING]))
        else $error("summary bit mismatch");

    halt_now_a: assert property ( // R16
        stop_now |-> exchange_halt)
        else $error("exchange not halted on error");

    restart_clear_a: assert property ( // R17
        unit_restart |=> (status_word == SVSF_WORD_RST) && (node_word == SVSF_WORD_RST))
        else $error("restart left state latched");

    // node range, input type, refused inputs, halt hold and the read path; a broken gate here is silent in the flags alone
    node_range_a: assert property ( // R11
        node_word[7:4] == 4'h0)
        else $error("stopped node out of range");

    stop_type_in_a: assert property ( // R13
        stop_now && !stopped_q && !unit_restart && (out_comm_err == 16'h0000)
        |=> node_word[SVSF_BIT_TYPE] == SVSF_TYPE_IN)
        else $error("input slave type not recorded");

    table_frozen_a: assert property ( // R15
        (phase_q != SVSF_LOAD) && !unit_restart |=> $stable(table_q) && $stable(mon_time_q))
        else $error("tables changed outside load");

    unreg_off_a: assert property ( // R6
        !reg_enable && !unreg_q && !unit_restart |=> !unreg_q)
        else $error("unregistered flag set while registration off");

    missing_off_a: assert property ( // R4
        !reg_enable && !status_word[SVSF_BIT_MISSING] && !unit_restart
        |=> !status_word[SVSF_BIT_MISSING])
        else $error("missing flag set while registration off");

    halt_hold_a: assert property ( // R16
        stopped_q |-> exchange_halt)
        else $error("exchange resumed after stop");

    read_status_a: assert property ( // R1
        rd_en && (rd_addr == SVSF_STATUS_OFS) |=> rd_data == $past(status_word))
        else $error("status word read wrong");

    read_node_a: assert property ( // R11
        rd_en && (rd_addr == SVSF_NODE_OFS) |=> rd_data == $past(node_word))
        else $error("node word read wrong");

endmodule
